// [rtl/nrsc_ctrl.v]
// Flash controller command sequencer with region protection, security bit and read cache
//
// Functional notes
// - Protect and release commands lock or unlock the region holding the target address.
// - Enter and exit low-power commands; status flag reads one while low power is active.
// - Boot area starts at row zero; writes and erases inside it are refused.
// - Boot fuse 7 protects none, 6 protects 2 rows, doubling to 128 at 0.
// - Emulation fuse 7 reserves none, 6 reserves 1 top row, doubling to 64.
// - Writes and erases in the emulation area ignore region locks.
// - While the security bit is set, external access to contents is blocked.
// - Set-security command sets the bit; a debugger chip erase clears it, and reset reloads it from the security fuse.
// - Set-security outcome is reported through the programming error flag.
// - Read cache is direct-mapped with eight 64-bit lines.
// - Cache is used when its off bit is zero, bypassed when one.
// - Two-bit fetch policy field selects one of three cache modes.
// - Flush command invalidates every cache line.
// - Any content-changing command invalidates the cache by itself.
// - Command runs only with key 0xa5 in bits 15:8; otherwise discarded, error set.
// - Ready clears on accept and sets on completion; commands while busy are discarded, error set.
// - Lock changes hold until reset; reset reloads the configured defaults.
`timescale 1ns/1ns
`default_nettype none
`include "nrsc_defines.vh"
module nrsc_ctrl #(
	parameter AW            = `NRSC_ADDR_W,
	parameter FLASH_ROWS    = `NRSC_FLASH_ROWS,
	parameter REGION_SHIFT  = `NRSC_REGION_SHIFT,
	parameter [15:0] PAGE_COUNT = `NRSC_PAGE_COUNT,
	parameter [2:0]  PAGE_SIZE  = `NRSC_PAGE_SIZE_CODE
) (
	input  wire             clock,
	input  wire             srst,
	input  wire             psel,
	input  wire             penable,
	input  wire             pwrite,
	input  wire [5:0]       paddr,
	input  wire [31:0]      pwdata,
	output reg  [31:0]      prdata_q,
	output reg              pready_q,
	output reg              pslverr_q,
	input  wire [2:0]       bootFuse,
	input  wire [2:0]       eepromFuse,
	input  wire [15:0]      lockDefault,
	input  wire             securityFuse,
	input  wire             pageBufLoaded,
	input  wire             autoAddrLoad,
	input  wire [AW-1:0]    autoAddr,
	input  wire             dbgChipErase,
	output reg              flashReq_q,
	output reg  [2:0]       flashOp_q,
	output reg  [AW-1:0]    flashAddr_q,
	input  wire             flashDone,
	input  wire             flashFail,
	input  wire             rdReq,
	input  wire [AW-1:0]    rdAddr,
	output wire [31:0]      rdData_q,
	output wire             rdValid_q,
	output wire             memReq_q,
	output wire [AW-4:0]    memAddr_q,
	input  wire [63:0]      memData,
	input  wire             memValid,
	output reg              irq_q,
	output reg              lowPower_q,
	output reg              extBlock_q,
	output reg              manualWrite_q,
	output reg  [3:0]       readWait_q,
	output reg  [1:0]       sleepPolicy_q
);
	localparam S_IDLE = 2'h0;
	localparam S_EXEC = 2'h1;
	localparam S_WAIT = 2'h2;
	localparam [31:0] CFG_RST = `NRSC_CFG_RESET;

	// Rows covered by the boot area fuse: 7 none, 6 two, doubling downward
	function [7:0] bootRows;
		input [2:0] fuse;
		begin
			if (fuse == `NRSC_FUSE_NONE)
				bootRows = 8'h00;
			else
				bootRows = 8'h02 << (3'h6 - fuse);
		end
	endfunction
	// Rows reserved at the top for emulation: 7 none, 6 one, doubling downward
	function [7:0] eeRows;
		input [2:0] fuse;
		begin
			if (fuse == `NRSC_FUSE_NONE)
				eeRows = 8'h00;
			else
				eeRows = 8'h01 << (3'h6 - fuse);
		end
	endfunction
	function [3:0] regionOf;
		input [AW-1:0] a;
		reg   [AW-1:0] s;
		begin
			s = a >> REGION_SHIFT;
			regionOf = s[3:0];
		end
	endfunction

	reg [1:0]    state_q;
	reg [6:0]    cmd_q;
	reg [AW-1:0] addr_q;
	reg [15:0]   lock_q;
	reg          sec_q;
	reg          progErr_q;
	reg          lockErr_q;
	reg          fault_q;
	reg          errFlag_q;
	reg [1:0]    ien_q;
	reg          cacheOff_q;
	reg [1:0]    fetchPolicy_q;
	reg [31:0]   rdMux;
	reg          rdHit;

	wire wrEn    = psel & penable & pready_q & pwrite;
	wire cmdWr   = wrEn & (paddr == `NRSC_OFS_CMD);
	wire keyOk   = pwdata[15:8] == `NRSC_EXEC_KEY;
	wire ready   = state_q == S_IDLE;
	wire accept  = cmdWr & keyOk & ready;
	wire cmdBad  = cmdWr & ~(keyOk & ready);

	wire [13:0] row    = addr_q[AW-1:`NRSC_ROW_SHIFT];
	wire        inBoot = row < {6'h00, bootRows(bootFuse)};
	wire        inEe   = row >= (FLASH_ROWS[13:0] - {6'h00, eeRows(eepromFuse)});
	wire        locked = lock_q[regionOf(addr_q)];
	wire        mainOp = (cmd_q == `NRSC_CMD_ERASE_ROW) | (cmd_q == `NRSC_CMD_WRITE_PAGE);
	wire        auxOp  = (cmd_q == `NRSC_CMD_ERASE_AUX) | (cmd_q == `NRSC_CMD_WRITE_AUX);
	// Emulation rows skip the region lock but never the boot area
	wire        refuse = inBoot | (locked & ~inEe);

	wire execNow  = state_q == S_EXEC;
	wire opDone   = (state_q == S_WAIT) & flashDone;
	wire lockSet  = execNow & mainOp & refuse;
	wire progSet  = cmdBad
	              | (execNow & auxOp & sec_q)
	              | (opDone & (flashOp_q == `NRSC_OP_SET_SEC) & flashFail);
	wire faultSet = opDone & flashFail & (flashOp_q != `NRSC_OP_SET_SEC);
	wire flushReq = (execNow & (cmd_q == `NRSC_CMD_FLUSH_CACHE))
	              | (opDone & (flashOp_q != `NRSC_OP_BUF_CLEAR))
	              | dbgChipErase;

	// Command sequencer
	always @(posedge clock) begin
		if (srst) begin
			state_q     <= S_IDLE;
			cmd_q       <= 7'h00;
			flashReq_q  <= 1'b0;
			flashOp_q   <= `NRSC_OP_ERASE_ROW;
			flashAddr_q <= {AW{1'b0}};
			lowPower_q  <= 1'b0;
			lock_q      <= lockDefault;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (accept) begin
						cmd_q   <= pwdata[6:0];
						state_q <= S_EXEC;
					end
				end
				S_EXEC: begin
					state_q     <= S_IDLE;
					flashAddr_q <= addr_q;
					case (cmd_q)
						`NRSC_CMD_ERASE_ROW, `NRSC_CMD_WRITE_PAGE: begin
							if (!refuse) begin
								flashOp_q  <= (cmd_q == `NRSC_CMD_ERASE_ROW) ?
								              `NRSC_OP_ERASE_ROW : `NRSC_OP_WRITE_PAGE;
								flashReq_q <= 1'b1;
								state_q    <= S_WAIT;
							end
						end
						`NRSC_CMD_ERASE_AUX, `NRSC_CMD_WRITE_AUX: begin
							if (!sec_q) begin
								flashOp_q  <= (cmd_q == `NRSC_CMD_ERASE_AUX) ?
								              `NRSC_OP_ERASE_AUX : `NRSC_OP_WRITE_AUX;
								flashReq_q <= 1'b1;
								state_q    <= S_WAIT;
							end
						end
						`NRSC_CMD_SET_SECURITY: begin
							flashOp_q  <= `NRSC_OP_SET_SEC;
							flashReq_q <= 1'b1;
							state_q    <= S_WAIT;
						end
						`NRSC_CMD_BUF_CLEAR: begin
							flashOp_q  <= `NRSC_OP_BUF_CLEAR;
							flashReq_q <= 1'b1;
							state_q    <= S_WAIT;
						end
						`NRSC_CMD_PROTECT:  lock_q[regionOf(addr_q)] <= 1'b1;
						`NRSC_CMD_RELEASE:  lock_q[regionOf(addr_q)] <= 1'b0;
						`NRSC_CMD_ENTER_LP: lowPower_q <= 1'b1;
						`NRSC_CMD_EXIT_LP:  lowPower_q <= 1'b0;
						default: begin
						end
					endcase
				end
				S_WAIT: begin
					if (flashDone) begin
						flashReq_q <= 1'b0;
						state_q    <= S_IDLE;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// Security bit, error flags and address register
	always @(posedge clock) begin
		if (srst) begin
			sec_q      <= securityFuse;
			extBlock_q <= securityFuse;
			progErr_q  <= 1'b0;
			lockErr_q  <= 1'b0;
			fault_q    <= 1'b0;
			errFlag_q  <= 1'b0;
			addr_q     <= {AW{1'b0}};
		end else begin
			if (dbgChipErase)
				sec_q <= 1'b0;
			else if (opDone & (flashOp_q == `NRSC_OP_SET_SEC) & ~flashFail)
				sec_q <= 1'b1;
			extBlock_q <= sec_q & ~dbgChipErase;
			// Set wins over a software clear in the same cycle
			if (progSet)
				progErr_q <= 1'b1;
			else if (wrEn & (paddr == `NRSC_OFS_STATUS) & pwdata[`NRSC_ST_PROGRAMMING_ERROR_BIT])
				progErr_q <= 1'b0;
			if (lockSet)
				lockErr_q <= 1'b1;
			else if (wrEn & (paddr == `NRSC_OFS_STATUS) & pwdata[`NRSC_ST_REGION_LOCK_ERROR_BIT])
				lockErr_q <= 1'b0;
			if (faultSet)
				fault_q <= 1'b1;
			else if (wrEn & (paddr == `NRSC_OFS_STATUS) & pwdata[`NRSC_ST_FAULT_BIT])
				fault_q <= 1'b0;
			if (progSet | lockSet | faultSet)
				errFlag_q <= 1'b1;
			else if (wrEn & (paddr == `NRSC_OFS_IFLAG) & pwdata[`NRSC_IRQ_ERROR_BIT])
				errFlag_q <= 1'b0;
			// System bus page-buffer writes load the address ahead of software
			if (autoAddrLoad)
				addr_q <= autoAddr;
			else if (wrEn & (paddr == `NRSC_OFS_ADDR))
				addr_q <= pwdata[AW-1:0];
		end
	end

	// Configuration and interrupt enables
	always @(posedge clock) begin
		if (srst) begin
			manualWrite_q <= CFG_RST[`NRSC_CFG_MANUAL_BIT];
			readWait_q    <= 4'h0;
			sleepPolicy_q <= 2'h0;
			fetchPolicy_q <= `NRSC_POLICY_NORMAL;
			cacheOff_q    <= 1'b0;
			ien_q         <= 2'h0;
			irq_q         <= 1'b0;
		end else begin
			if (wrEn & (paddr == `NRSC_OFS_CFG)) begin
				manualWrite_q <= pwdata[`NRSC_CFG_MANUAL_BIT];
				readWait_q    <= pwdata[`NRSC_CFG_WAIT_LSB+:4];
				sleepPolicy_q <= pwdata[`NRSC_CFG_SLEEP_LSB+:2];
				fetchPolicy_q <= pwdata[`NRSC_CFG_POLICY_LSB+:2];
				cacheOff_q    <= pwdata[`NRSC_CFG_CACHEOFF_BIT];
			end
			if (wrEn & (paddr == `NRSC_OFS_IENSET))
				ien_q <= ien_q | pwdata[1:0];
			else if (wrEn & (paddr == `NRSC_OFS_IENCLR))
				ien_q <= ien_q & ~pwdata[1:0];
			irq_q <= |({errFlag_q, ready} & ien_q);
		end
	end

	// Read data selection
	always @* begin
		rdMux = 32'h00000000;
		rdHit = 1'b1;
		case (paddr)
			`NRSC_OFS_CMD:    rdMux = {25'h0000000, cmd_q};
			`NRSC_OFS_CFG:    rdMux = {13'h0000, cacheOff_q, fetchPolicy_q, 6'h00,
			                           sleepPolicy_q, manualWrite_q, 2'h0, readWait_q, 1'b0};
			`NRSC_OFS_GEO:    rdMux = {13'h0000, PAGE_SIZE, PAGE_COUNT};
			`NRSC_OFS_IENCLR: rdMux = {30'h00000000, ien_q};
			`NRSC_OFS_IENSET: rdMux = {30'h00000000, ien_q};
			`NRSC_OFS_IFLAG:  rdMux = {30'h00000000, errFlag_q, ready};
			`NRSC_OFS_STATUS: rdMux = {23'h000000, sec_q, 3'h0, fault_q, lockErr_q,
			                           progErr_q, pageBufLoaded, lowPower_q};
			`NRSC_OFS_ADDR:   rdMux = {{(32-AW){1'b0}}, addr_q};
			`NRSC_OFS_LOCK:   rdMux = {16'h0000, lock_q};
			default:          rdHit = 1'b0;
		endcase
	end

	// Peripheral bus slave: one wait-free access phase, read data taken at setup
	always @(posedge clock) begin
		if (srst) begin
			prdata_q  <= 32'h00000000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= psel & ~penable;
			if (psel & ~penable) begin
				prdata_q  <= pwrite ? 32'h00000000 : rdMux;
				pslverr_q <= ~rdHit;
			end
		end
	end

	nrsc_cache #(
		.LINES (8),
		.IDX_W (3),
		.AW    (AW)
	) u_cache (
		.clock       (clock),
		.srst        (srst),
		.cacheOff    (cacheOff_q),
		.fetchPolicy (fetchPolicy_q),
		.flush       (flushReq),
		.rdReq       (rdReq),
		.rdAddr      (rdAddr),
		.rdData_q    (rdData_q),
		.rdValid_q   (rdValid_q),
		.memReq_q    (memReq_q),
		.memAddr_q   (memAddr_q),
		.memData     (memData),
		.memValid    (memValid)
	);
endmodule // nrsc_ctrl
`default_nettype wire

// [pkg/nrsc_defines.vh]
// Register offsets, field positions, command codes and reset values of the flash controller
`ifndef NRSC_DEFINES_VH
`define NRSC_DEFINES_VH
`define NRSC_OFS_CMD     6'h00
`define NRSC_OFS_CFG     6'h04
`define NRSC_OFS_GEO     6'h08
`define NRSC_OFS_IENCLR  6'h0c
`define NRSC_OFS_IENSET  6'h10
`define NRSC_OFS_IFLAG   6'h14
`define NRSC_OFS_STATUS  6'h18
`define NRSC_OFS_ADDR    6'h1c
`define NRSC_OFS_LOCK    6'h20
`define NRSC_EXEC_KEY    8'ha5
`define NRSC_CMD_ERASE_ROW     7'h02
`define NRSC_CMD_WRITE_PAGE    7'h04
`define NRSC_CMD_ERASE_AUX     7'h05
`define NRSC_CMD_WRITE_AUX     7'h06
`define NRSC_CMD_PROTECT       7'h40
`define NRSC_CMD_RELEASE       7'h41
`define NRSC_CMD_ENTER_LP      7'h42
`define NRSC_CMD_EXIT_LP       7'h43
`define NRSC_CMD_BUF_CLEAR     7'h44
`define NRSC_CMD_SET_SECURITY  7'h45
`define NRSC_CMD_FLUSH_CACHE   7'h46
`define NRSC_OP_ERASE_ROW  3'h0
`define NRSC_OP_WRITE_PAGE 3'h1
`define NRSC_OP_ERASE_AUX  3'h2
`define NRSC_OP_WRITE_AUX  3'h3
`define NRSC_OP_SET_SEC    3'h4
`define NRSC_OP_BUF_CLEAR  3'h5
`define NRSC_CFG_MANUAL_BIT   7
`define NRSC_CFG_WAIT_LSB     1
`define NRSC_CFG_SLEEP_LSB    8
`define NRSC_CFG_POLICY_LSB   16
`define NRSC_CFG_CACHEOFF_BIT 18
`define NRSC_ST_PRM_BIT    0
`define NRSC_ST_LOAD_BIT   1
`define NRSC_ST_PROGRAMMING_ERROR_BIT  2
`define NRSC_ST_REGION_LOCK_ERROR_BIT  3
`define NRSC_ST_FAULT_BIT  4
`define NRSC_ST_SEC_BIT    8
`define NRSC_IRQ_READY_BIT 0
`define NRSC_IRQ_ERROR_BIT 1
`define NRSC_POLICY_NORMAL   2'h0
`define NRSC_POLICY_NOALLOC  2'h1
`define NRSC_POLICY_DETERM   2'h2
`define NRSC_FUSE_NONE       3'h7
`define NRSC_ROW_SHIFT       8
`define NRSC_REGION_SHIFT    14
`define NRSC_FLASH_ROWS      1024
`define NRSC_PAGE_COUNT      16'h1000
`define NRSC_PAGE_SIZE_CODE  3'h3
`define NRSC_CFG_RESET       32'h00000000
`define NRSC_ADDR_W          22
`endif

// [rtl/nrsc_cache.v]
// Direct-mapped read cache of eight 64-bit lines between system bus reads and flash
`timescale 1ns/1ns
`default_nettype none
`include "nrsc_defines.vh"
module nrsc_cache #(
	parameter LINES = 8,
	parameter IDX_W = 3,
	parameter AW    = `NRSC_ADDR_W
) (
	input  wire             clock,
	input  wire             srst,
	input  wire             cacheOff,
	input  wire [1:0]       fetchPolicy,
	input  wire             flush,
	input  wire             rdReq,
	input  wire [AW-1:0]    rdAddr,
	output reg  [31:0]      rdData_q,
	output reg              rdValid_q,
	output reg              memReq_q,
	output reg  [AW-4:0]    memAddr_q,
	input  wire [63:0]      memData,
	input  wire             memValid
);
	localparam TAG_W = AW - 3 - IDX_W;
	reg  [LINES-1:0] valid_q;
	reg  [TAG_W-1:0] tag_q [0:LINES-1];
	reg  [63:0]      data_q [0:LINES-1];
	reg              busy_q;
	reg              wordSel_q;
	wire [IDX_W-1:0] idx    = rdAddr[3+IDX_W-1:3];
	wire [TAG_W-1:0] tag    = rdAddr[AW-1:3+IDX_W];
	wire [IDX_W-1:0] fillIdx = memAddr_q[IDX_W-1:0];
	wire             useHit = ~cacheOff & (fetchPolicy != `NRSC_POLICY_DETERM);
	wire             hit    = useHit & valid_q[idx] & (tag_q[idx] == tag);
	wire             alloc  = ~cacheOff & (fetchPolicy != `NRSC_POLICY_NOALLOC);
	integer i;

	always @(posedge clock) begin
		if (srst) begin
			valid_q   <= {LINES{1'b0}};
			busy_q    <= 1'b0;
			wordSel_q <= 1'b0;
			rdData_q  <= 32'h00000000;
			rdValid_q <= 1'b0;
			memReq_q  <= 1'b0;
			memAddr_q <= {(AW-3){1'b0}};
			for (i = 0; i < LINES; i = i + 1) begin
				tag_q[i]  <= {TAG_W{1'b0}};
				data_q[i] <= 64'h0000000000000000;
			end
		end else begin
			rdValid_q <= 1'b0;
			if (!busy_q && rdReq) begin
				if (hit) begin
					rdData_q  <= rdAddr[2] ? data_q[idx][63:32] : data_q[idx][31:0];
					rdValid_q <= 1'b1;
				end else begin
					busy_q    <= 1'b1;
					memReq_q  <= 1'b1;
					memAddr_q <= rdAddr[AW-1:3];
					wordSel_q <= rdAddr[2];
				end
			end else if (busy_q && memValid) begin
				busy_q    <= 1'b0;
				memReq_q  <= 1'b0;
				rdValid_q <= 1'b1;
				rdData_q  <= wordSel_q ? memData[63:32] : memData[31:0];
				if (alloc) begin
					data_q[fillIdx]  <= memData;
					tag_q[fillIdx]   <= memAddr_q[AW-4:IDX_W];
					valid_q[fillIdx] <= 1'b1;
				end
			end
			// Flush wins over a fill in the same cycle: the fetched line may be stale
			if (flush) begin
				valid_q <= {LINES{1'b0}};
			end
		end
	end
endmodule // nrsc_cache
`default_nettype wire

// [dv/nrsc_ctrl_assertions.sv]
// Concurrent checks on the flash controller top ports
`timescale 1ns/1ns
`default_nettype none
module nrsc_ctrl_assertions #(
	parameter AW = 22
) (
	input wire logic          clock,
	input wire logic          srst,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic [5:0]    paddr,
	input wire logic [31:0]   prdata_q,
	input wire logic          pready_q,
	input wire logic          pslverr_q,
	input wire logic [2:0]    bootFuse,
	input wire logic          dbgChipErase,
	input wire logic          flashReq_q,
	input wire logic [2:0]    flashOp_q,
	input wire logic [AW-1:0] flashAddr_q,
	input wire logic          flashDone,
	input wire logic          rdValid_q,
	input wire logic          memReq_q,
	input wire logic [AW-4:0] memAddr_q,
	input wire logic          memValid,
	input wire logic          extBlock_q
);
	logic [13:0] bootRows;
	// Rows guarded by the boot fuse
	always_comb bootRows = (bootFuse == 3'h7) ? 14'h0000 : (14'h0002 << (3'h6 - bootFuse));
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_flashEnd;
		flashReq_q && flashDone;
	endsequence
	sequence s_memEnd;
		memReq_q && memValid;
	endsequence
	chk_setup_ready: assert property (s_setup |=> pready_q)
		else $error("no ready after setup");
	chk_ready_single: assert property (pready_q |=> !pready_q)
		else $error("ready longer than one cycle");
	chk_idle_quiet: assert property (!psel |=> !pready_q)
		else $error("ready without select");
	chk_unmapped_err: assert property (s_setup and paddr > 6'h23 |=> pslverr_q && prdata_q == 32'h0)
		else $error("unmapped access not flagged");
	chk_mapped_ok: assert property (s_setup and paddr <= 6'h20 |=> !pslverr_q)
		else $error("mapped access flagged");
	chk_flash_hold: assert property (flashReq_q && !flashDone |=> flashReq_q && $stable(flashOp_q) && $stable(flashAddr_q))
		else $error("flash request changed before done");
	chk_flash_drop: assert property (s_flashEnd |=> !flashReq_q)
		else $error("flash request kept after done");
	chk_mem_hold: assert property (memReq_q && !memValid |=> memReq_q && $stable(memAddr_q))
		else $error("line fetch changed before answer");
	chk_fetch_answer: assert property (s_memEnd |=> rdValid_q && !memReq_q)
		else $error("no read data after line fetch");
	chk_boot_guard: assert property ($rose(flashReq_q) && flashOp_q <= 3'h1 |-> flashAddr_q[AW-1:8] >= bootRows)
		else $error("write or erase reached boot rows");
	chk_erase_unblock: assert property (dbgChipErase |-> ##[1:2] !extBlock_q)
		else $error("chip erase left access blocked");
	chk_sec_sticky: assert property (extBlock_q && !dbgChipErase && !$past(dbgChipErase) |=> extBlock_q)
		else $error("security bit cleared without chip erase");
endmodule // nrsc_ctrl_assertions
bind nrsc_ctrl nrsc_ctrl_assertions #(.AW(AW)) u_nrsc_ctrl_assertions (.clock, .srst, .psel, .penable, .paddr,
	.prdata_q, .pready_q, .pslverr_q, .bootFuse, .dbgChipErase, .flashReq_q, .flashOp_q, .flashAddr_q,
	.flashDone, .rdValid_q, .memReq_q, .memAddr_q, .memValid, .extBlock_q);
`default_nettype wire

// [dv/nrsc_flash_model.sv]
// Far-side model of the flash array and its line fetch port
`timescale 1ns/1ns
`default_nettype none
module nrsc_flash_model #(
	parameter int DLY  = 4,
	parameter int MDLY = 3
) (
	input  wire logic        clock,
	input  wire logic        srst,
	input  wire logic        failNext,
	input  wire logic        flashReq,
	output var  logic        flashDone,
	output var  logic        flashFail,
	output var  logic [7:0]  reqCnt,
	input  wire logic        memReq,
	input  wire logic [18:0] memAddr,
	output wire logic [63:0] memData,
	output var  logic        memValid,
	output var  logic [7:0]  memCnt
);
	int fc;
	int mc;
	wire logic [63:0] line = {13'h1a5, memAddr, 13'h0c3, ~memAddr};
	// Data only means something in the answer cycle
	assign memData = memValid ? line : ~line;
	always @(posedge clock) begin
		if (srst) begin
			{flashDone, flashFail, memValid, reqCnt, memCnt} <= '0;
			fc <= 0;
			mc <= 0;
		end else begin
			flashDone <= 1'b0;
			flashFail <= ~flashFail;
			memValid <= 1'b0;
			if (flashReq && !flashDone) fc <= fc + 1;
			if (flashReq && !flashDone && fc == DLY) begin
				flashDone <= 1'b1;
				flashFail <= failNext;
				reqCnt <= reqCnt + 8'h01;
				fc <= 0;
			end
			if (memReq && !memValid) mc <= mc + 1;
			if (memReq && !memValid && mc == MDLY) begin
				memValid <= 1'b1;
				memCnt <= memCnt + 8'h01;
				mc <= 0;
			end
		end
	end
endmodule // nrsc_flash_model
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the flash controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
	typedef struct {logic [2:0] k; logic [5:0] a; logic [31:0] d; logic [31:0] m;} nrsc_row_t;
	localparam logic [2:0] W = 3'h0, R = 3'h1, C = 3'h2, F = 3'h3, E = 3'h4, N = 3'h5;
	localparam logic [31:0] Z = 32'h0;
	logic        clock = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        securityFuse = 1'b0, dbgChipErase = 1'b0, failNext = 1'b0, rdReq = 1'b0;
	logic        pageBufLoaded = 1'b0, autoAddrLoad = 1'b0;
	logic [5:0]  paddr = 6'h00;
	logic [31:0] pwdata = 32'h0, r, m0;
	logic [21:0] rdAddr = 22'h0, autoAddr = 22'h0;
	wire logic [31:0] prdata_q, rdData_q;
	wire logic [21:0] flashAddr_q;
	wire logic [18:0] memAddr_q;
	wire logic [63:0] memData;
	wire logic [7:0]  reqCnt, memCnt;
	wire logic [3:0]  readWait_q;
	wire logic [2:0]  flashOp_q;
	wire logic [1:0]  sleepPolicy_q;
	wire logic pready_q, pslverr_q, flashReq_q, flashDone, flashFail, rdValid_q, memReq_q, memValid;
	wire logic irq_q, lowPower_q, extBlock_q, manualWrite_q;
	int error_cnt = 0, n_checks = 0, p;
	nrsc_row_t rows[$];
	always #10 clock = ~clock;
	nrsc_ctrl u_nrsc_ctrl (.clock, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q, .pready_q,
		.pslverr_q, .bootFuse(3'h6), .eepromFuse(3'h6), .lockDefault(16'h8000), .securityFuse,
		.pageBufLoaded, .autoAddrLoad, .autoAddr, .dbgChipErase, .flashReq_q, .flashOp_q,
		.flashAddr_q, .flashDone, .flashFail, .rdReq, .rdAddr, .rdData_q, .rdValid_q, .memReq_q, .memAddr_q,
		.memData, .memValid, .irq_q, .lowPower_q, .extBlock_q, .manualWrite_q, .readWait_q, .sleepPolicy_q);
	nrsc_flash_model #(.DLY(20), .MDLY(3)) u_nrsc_flash_model (.clock, .srst, .failNext,
		.flashReq(flashReq_q), .flashDone, .flashFail, .reqCnt, .memReq(memReq_q), .memAddr(memAddr_q),
		.memData, .memValid, .memCnt);
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [5:0] a, input logic [31:0] d);
		int k;
		psel = 1'b1;
		pwrite = w;
		paddr = a;
		pwdata = d;
		@(negedge clock);
		penable = 1'b1;
		for (k = 0; k < 8 && pready_q !== 1'b1; k++) @(negedge clock);
		r = prdata_q;
		@(negedge clock);
		psel = 1'b0;
		penable = 1'b0;
		@(negedge clock);
	endtask
	task automatic waitReady;
		for (int k = 0; k < 200; k++) begin
			apb(1'b0, 6'h14, Z);
			if (r[0] === 1'b1) break;
		end
	endtask
	task automatic cmd(input logic [6:0] c);
		apb(1'b1, 6'h00, {16'h0, 8'ha5, 1'b0, c});
		waitReady;
	endtask
	task automatic crd(input logic [21:0] a);
		int k;
		rdAddr = a;
		rdReq = 1'b1;
		@(negedge clock);
		rdReq = 1'b0;
		for (k = 0; k < 30 && rdValid_q !== 1'b1; k++) @(negedge clock);
		cmp(rdData_q, a[2] ? {13'h1a5, a[21:3]} : {13'h0c3, ~a[21:3]});
		@(negedge clock);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clock);
		error_cnt++;
		$display("FAIL t=%0t watchdog expired", $time);
		print_verdict;
	end
	initial begin
		repeat (2) @(negedge clock);
		srst = 1'b0;
		@(negedge clock);
		rows = '{'{R, 6'h08, 32'h31000, 32'h7ffff},
			'{W, 6'h08, Z, Z}, '{R, 6'h08, 32'h31000, 32'h7ffff},
			'{R, 6'h20, 32'h8000, 32'hffff},
			'{C, 6'h00, 32'h42, Z}, '{R, 6'h18, 32'h1, 32'h1},
			'{C, 6'h00, 32'h43, Z}, '{R, 6'h18, Z, 32'h1},
			'{W, 6'h1c, 32'hc000, Z}, '{C, 6'h00, 32'h40, Z}, '{R, 6'h20, 32'h8008, 32'hffff},
			'{C, 6'h00, 32'h41, Z}, '{R, 6'h20, 32'h8000, 32'hffff},
			'{W, 6'h00, 32'h5a42, Z}, '{R, 6'h18, 32'h4, 32'h5},
			'{W, 6'h1c, 32'h100, Z}, '{C, 6'h00, 32'h2, Z}, '{R, 6'h18, 32'h8, 32'h8},
			'{W, 6'h18, 32'h1c, Z}, '{W, 6'h1c, 32'h200, Z}, '{C, 6'h00, 32'h2, Z},
			'{R, 6'h18, Z, 32'h8}, '{N, 6'h00, 32'h1, Z},
			'{W, 6'h1c, 32'h3fe00, Z}, '{C, 6'h00, 32'h2, Z}, '{R, 6'h18, 32'h8, 32'h8},
			'{W, 6'h1c, 32'h3ff00, Z}, '{C, 6'h00, 32'h4, Z}, '{N, 6'h00, 32'h2, Z},
			'{W, 6'h18, 32'h1c, Z}, '{F, 6'h00, 32'h1, Z}, '{C, 6'h00, 32'h45, Z},
			'{R, 6'h18, 32'h4, 32'h104},
			'{F, 6'h00, Z, Z}, '{W, 6'h18, 32'h1c, Z}, '{C, 6'h00, 32'h45, Z},
			'{R, 6'h18, 32'h100, 32'h104},
			'{C, 6'h00, 32'h6, Z}, '{R, 6'h18, 32'h104, 32'h104}, '{N, 6'h00, 32'h4, Z},
			'{E, 6'h00, Z, Z}, '{R, 6'h18, Z, 32'h100},
			'{C, 6'h00, 32'h44, Z}, '{N, 6'h00, 32'h5, Z},
			'{W, 6'h04, 32'h6039e, Z}, '{R, 6'h04, 32'h6039e, 32'h7039e},
			'{R, 6'h24, Z, 32'hffffffff}};
		foreach (rows[j]) begin
			case (rows[j].k)
				W: apb(1'b1, rows[j].a, rows[j].d);
				R: begin
					apb(1'b0, rows[j].a, Z);
					cmp(r & rows[j].m, rows[j].d);
				end
				C: cmd(rows[j].d[6:0]);
				F: failNext = rows[j].d[0];
				E: begin
					dbgChipErase = 1'b1;
					@(negedge clock);
					dbgChipErase = 1'b0;
					@(negedge clock);
				end
				default: cmp({24'h0, reqCnt}, rows[j].d);
			endcase
		end
		cmp({31'h0, pslverr_q}, 32'h1);
		cmp({25'h0, manualWrite_q, readWait_q, sleepPolicy_q}, 32'h7f);
		apb(1'b1, 6'h04, Z);
		apb(1'b1, 6'h10, 32'h1);
		cmp({31'h0, irq_q}, 32'h1);
		apb(1'b1, 6'h0c, 32'h1);
		cmp({31'h0, irq_q}, Z);
		$display("register table test done");
		apb(1'b1, 6'h18, 32'h1c);
		apb(1'b1, 6'h1c, 32'h200);
		apb(1'b1, 6'h00, 32'ha502);
		apb(1'b0, 6'h14, Z);
		cmp(r & 32'h1, Z);
		apb(1'b1, 6'h00, 32'ha542);
		waitReady;
		apb(1'b0, 6'h18, Z);
		cmp(r & 32'h5, 32'h4);
		pageBufLoaded = 1'b1;
		autoAddr = 22'h2a5f8;
		autoAddrLoad = 1'b1;
		@(negedge clock);
		autoAddrLoad = 1'b0;
		apb(1'b0, 6'h1c, Z);
		cmp(r, 32'h2a5f8);
		apb(1'b0, 6'h18, Z);
		cmp(r & 32'h3, 32'h2);
		$display("busy command test done");
		m0 = {24'h0, memCnt};
		crd(22'h40);
		crd(22'h44);
		cmp({24'h0, memCnt}, m0 + 32'h1);
		crd(22'h80);
		crd(22'h40);
		cmp({24'h0, memCnt}, m0 + 32'h3);
		cmd(7'h46);
		crd(22'h40);
		cmp({24'h0, memCnt}, m0 + 32'h4);
		cmd(7'h02);
		crd(22'h40);
		cmp({24'h0, memCnt}, m0 + 32'h5);
		for (p = 0; p < 3; p++) begin
			apb(1'b1, 6'h04, 32'h10000 << p);
			m0 = {24'h0, memCnt};
			crd(22'h1000);
			crd(22'h1000);
			cmp({24'h0, memCnt}, m0 + 32'h2);
		end
		apb(1'b1, 6'h04, Z);
		m0 = {24'h0, memCnt};
		crd(22'h1000);
		cmp({24'h0, memCnt}, m0);
		$display("cache test done");
		apb(1'b1, 6'h1c, 32'hc000);
		cmd(7'h40);
		securityFuse = 1'b1;
		srst = 1'b1;
		repeat (2) @(negedge clock);
		srst = 1'b0;
		@(negedge clock);
		apb(1'b0, 6'h20, Z);
		cmp(r & 32'hffff, 32'h8000);
		cmp({31'h0, extBlock_q}, 32'h1);
		$display("reset test done");
		print_verdict;
	end
endmodule // testbench
`default_nettype wire
